// ---- common/irq_prio_regs.svh ----
// Register offsets, field positions, reset values and timing counts of the priority unit.
// Assumes an AXI4-Lite byte address of which only the low eight bits are decoded.
`ifndef IRQ_PRIO_REGS_SVH
`define IRQ_PRIO_REGS_SVH

`define IRQ_ADDR_W 8
`define IRQ_ENABLE_OFFSET 8'ha8
`define IRQ_PRIORITY_OFFSET 8'hb8
`define IRQ_STATUS_OFFSET 8'hc0

`define IRQ_ENABLE_RESET 8'h00
`define IRQ_PRIORITY_RESET 6'h00

`define GLOBAL_IRQ_ENABLE_BIT 7
`define SPARE_SOFTWARE_FLAG_BIT 6
`define TIMER2_IRQ_ENABLE_BIT 5
`define SERIAL_IRQ_ENABLE_BIT 4
`define TIMER1_IRQ_ENABLE_BIT 3
`define EXT1_IRQ_ENABLE_BIT 2
`define TIMER0_IRQ_ENABLE_BIT 1
`define EXT0_IRQ_ENABLE_BIT 0

`define SOURCE_COUNT 6
`define DETECT_CYCLES 3'd1
`define CALL_CYCLES 3'd4
`define VECTOR_BASE 16'h0003
`define VECTOR_STEP_SHIFT 3

`define AXI_RESP_OKAY 2'b00
`define AXI_RESP_SLVERR 2'b10

`endif

// ---- common/irq_prio_pkg.sv ----
// Types shared by the priority unit and its bench.
// Assumes irq_prio_regs.svh supplies the numeric constants.
package irq_prio_pkg;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axil_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_resp_type;

  // Pending flags as raised by the peripherals, already in the system clock domain.
  typedef struct packed {
    logic timer2_overflow_flag;
    logic serial_transmit_done;
    logic serial_receive_done;
    logic timer1_overflow_flag;
    logic external_request_1;
    logic timer0_overflow_flag;
    logic external_request_0;
  } pending_flags_type;

  typedef struct packed {
    logic insn_done;
    logic return_from_interrupt;
  } sequencer_event_type;

  typedef struct packed {
    logic call_active;
    logic call_done;
    logic call_level;
    logic [2:0] source;
    logic [15:0] address;
  } vector_call_type;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b01,
    SEQ_CALL = 2'b10
  } seq_state_type;

endpackage

// ---- hdl/irq_rank_picker.sv ----
// Fixed-rank picker: returns the lowest-numbered set request.
// Assumes the requests are already qualified and registered by the caller.
module irq_rank_picker #(
  parameter int WIDTH = 6
) (
  input wire logic [WIDTH-1:0] i_request,
  output logic o_valid,
  output logic [2:0] o_index
);

  always_comb begin
    o_valid = 1'b0;
    o_index = 3'd0;
    // Scanning from the top down lets the lowest number win, which is the highest rank.
    for (int i = WIDTH - 1; i >= 0; i--) begin
      if (i_request[i]) begin
        o_valid = 1'b1;
        o_index = 3'(i);
      end
    end
  end

endmodule

// ---- hdl/irq_prio_unit.sv ----
// Two-level interrupt priority and vector-call unit with its AXI4-Lite register slave.
// Assumes pending flags and sequencer strobes are synchronous to i_clk.
//
// How it works
// - Each source has its own priority bit choosing low or high level.
// - A pending high request preempts a running low-level routine.
// - A running high-level routine is never preempted by any request.
// - Reset clears every priority bit, so all sources start at low level.
// - Of simultaneous requests the high-level one is serviced first.
// - Requests sharing a level are arbitrated by fixed source rank.
// - All pending requests are sampled and decoded every clock cycle.
// - Fastest response is 1 detect cycle plus a 4-cycle vector call.
// - After a return from interrupt one more instruction runs before vectoring.
// - Worst unblocked response is 18 cycles; the sequencer's instruction timing sets it.
// - Equal or higher active level holds a request until return plus one instruction.
// - Enable register at 0xa8, resets to zero: global, spare flag, six enables.
// - Global enable low masks every source regardless of individual enables.
// - A serviced request produces a long call to the source's fixed vector.
// - A flag still set after return raises a new request at once.
// - Same-level rank follows source number, external 0 highest.
//
// Design decision made here: the AXI4-Lite slave port.
module irq_prio_unit (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire irq_prio_pkg::axil_req_type i_axil,
  output irq_prio_pkg::axil_resp_type o_axil,
  input wire irq_prio_pkg::pending_flags_type i_flags,
  input wire irq_prio_pkg::sequencer_event_type i_seq,
  output irq_prio_pkg::vector_call_type o_vector,
  output logic [1:0] o_in_service
);
  import irq_prio_pkg::*;

`include "irq_prio_regs.svh"

  typedef struct packed {
    // Register bus slave.
    logic awready;
    logic wready;
    logic aw_full;
    logic w_full;
    logic [7:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    // Software-visible configuration.
    logic [7:0] irq_enable;
    logic [5:0] priority_select_reg;
    // Interrupt core.
    logic [5:0] detected;
    logic in_svc_low;
    logic in_svc_high;
    logic after_return;
    seq_state_type seq;
    logic [2:0] call_count;
    logic call_active;
    logic call_done;
    logic call_level;
    logic [2:0] call_source;
    logic [15:0] call_address;
  } unit_state_type;

  // Every field has a constant reset value, so the whole state clears in one assignment.
  localparam unit_state_type RESET_STATE = '{
    awready: 1'b0,
    wready: 1'b0,
    aw_full: 1'b0,
    w_full: 1'b0,
    aw_addr: 8'h00,
    w_byte: 8'h00,
    w_lane0: 1'b0,
    bvalid: 1'b0,
    bresp: `AXI_RESP_OKAY,
    arready: 1'b0,
    rvalid: 1'b0,
    rdata: 32'h0000_0000,
    rresp: `AXI_RESP_OKAY,
    irq_enable: `IRQ_ENABLE_RESET,
    priority_select_reg: `IRQ_PRIORITY_RESET,
    detected: 6'h00,
    in_svc_low: 1'b0,
    in_svc_high: 1'b0,
    after_return: 1'b0,
    seq: SEQ_IDLE,
    call_count: 3'd0,
    call_active: 1'b0,
    call_done: 1'b0,
    call_level: 1'b0,
    call_source: 3'd0,
    call_address: 16'h0000
  };

  unit_state_type state;
  unit_state_type next_state;

  // Request decode; each bit is one source, in rank order.
  logic [5:0] raw_request;
  logic [5:0] high_request;
  logic [5:0] low_request;
  logic high_valid;
  logic low_valid;
  logic [2:0] high_index;
  logic [2:0] low_index;
  logic [31:0] status_word;

  // Serial enable covers both serial flags; each timer enable sees only its own overflow.
  always_comb begin
    raw_request[0] = i_flags.external_request_0
      & state.irq_enable[`EXT0_IRQ_ENABLE_BIT];
    raw_request[1] = i_flags.timer0_overflow_flag
      & state.irq_enable[`TIMER0_IRQ_ENABLE_BIT];
    raw_request[2] = i_flags.external_request_1
      & state.irq_enable[`EXT1_IRQ_ENABLE_BIT];
    raw_request[3] = i_flags.timer1_overflow_flag
      & state.irq_enable[`TIMER1_IRQ_ENABLE_BIT];
    raw_request[4] = (i_flags.serial_receive_done | i_flags.serial_transmit_done)
      & state.irq_enable[`SERIAL_IRQ_ENABLE_BIT];
    raw_request[5] = i_flags.timer2_overflow_flag
      & state.irq_enable[`TIMER2_IRQ_ENABLE_BIT];
    if (!state.irq_enable[`GLOBAL_IRQ_ENABLE_BIT]) begin
      raw_request = 6'h00;
    end
  end

  // Split the registered requests by their level bit.
  assign high_request = state.detected & state.priority_select_reg;
  assign low_request = state.detected & ~state.priority_select_reg;

  // Two pickers run side by side so the level decision costs no extra cycle.
  // Only the six sources behind the first enable register are handled here.
  irq_rank_picker #(
    .WIDTH(`SOURCE_COUNT)
  ) u_high_picker (
    .i_request(high_request),
    .o_valid(high_valid),
    .o_index(high_index)
  );

  irq_rank_picker #(
    .WIDTH(`SOURCE_COUNT)
  ) u_low_picker (
    .i_request(low_request),
    .o_valid(low_valid),
    .o_index(low_index)
  );

  // Status is a read-only view of the live state; its upper bits read zero.
  assign status_word = {
    19'h00000,
    state.detected,
    state.call_source,
    state.after_return,
    state.call_active,
    state.in_svc_high,
    state.in_svc_low
  };

  always_comb begin
    logic take_high;
    logic take_low;
    logic boundary;
    logic [2:0] pick;
    logic do_write;
    take_high = 1'b0;
    take_low = 1'b0;
    boundary = 1'b0;
    pick = 3'd0;
    do_write = 1'b0;
    next_state = state;
    // The done strobe lasts one cycle unless the call logic raises it again below.
    next_state.call_done = 1'b0;

    // The sampled flags form the detect cycle of every response.
    next_state.detected = raw_request;

    // A flag left set keeps its bit in detected, so it asks again straight after return.
    // Vectoring is only considered at the end of an ordinary instruction; the return
    // itself never counts, so at least one more instruction runs first.
    boundary = i_seq.insn_done & ~i_seq.return_from_interrupt;

    // High requests win over low ones, and only an idle high level lets them in.
    take_high = high_valid & ~state.in_svc_high;
    take_low = low_valid & ~state.in_svc_high & ~state.in_svc_low;
    pick = take_high ? high_index : low_index;

    if (i_seq.return_from_interrupt) begin
      // The return closes the highest level in service and leaves a preempted low one.
      // A return with nothing in service leaves both levels clear.
      if (state.in_svc_high) begin
        next_state.in_svc_high = 1'b0;
      end else begin
        next_state.in_svc_low = 1'b0;
      end
      next_state.after_return = 1'b1;
    end else if (i_seq.insn_done) begin
      next_state.after_return = 1'b0;
    end

    unique case (state.seq)
      SEQ_IDLE: begin
        if (boundary && (take_high || take_low)) begin
          next_state.seq = SEQ_CALL;
          next_state.call_active = 1'b1;
          next_state.call_count = `CALL_CYCLES - 3'd1;
          next_state.call_level = take_high;
          next_state.call_source = pick;
          next_state.call_address = `VECTOR_BASE
            + {10'h000, pick, 3'b000};
          // Marking the level now makes a later request of the same or a lower level see this routine as running.
          if (take_high) begin
            next_state.in_svc_high = 1'b1;
          end else begin
            next_state.in_svc_low = 1'b1;
          end
        end
      end
      SEQ_CALL: begin
        // Requests raised during the call stay in detected and are weighed afterwards.
        if (state.call_count == 3'd0) begin
          next_state.seq = SEQ_IDLE;
          next_state.call_active = 1'b0;
          next_state.call_done = 1'b1;
        end else begin
          next_state.call_count = state.call_count - 3'd1;
        end
      end
      default: begin
        next_state.seq = SEQ_IDLE;
        next_state.call_active = 1'b0;
      end
    endcase

    // Write channel: address and data are taken in either order.
    // Only byte lane 0 carries register bits and there are no single-bit writes, so
    // software changes one enable by writing back the whole byte.
    if (i_axil.awvalid && state.awready) begin
      next_state.aw_full = 1'b1;
      next_state.aw_addr = i_axil.awaddr;
    end
    if (i_axil.wvalid && state.wready) begin
      next_state.w_full = 1'b1;
      next_state.w_byte = i_axil.wdata[7:0];
      next_state.w_lane0 = i_axil.wstrb[0];
    end
    if (state.bvalid && i_axil.bready) begin
      next_state.bvalid = 1'b0;
    end
    // A write completes only once both halves are held and the previous reply has gone.
    do_write = state.aw_full & state.w_full & ~state.bvalid;
    if (do_write) begin
      next_state.aw_full = 1'b0;
      next_state.w_full = 1'b0;
      next_state.bvalid = 1'b1;
      next_state.bresp = `AXI_RESP_OKAY;
      unique case ({state.aw_addr[7:2], 2'b00})
        `IRQ_ENABLE_OFFSET: begin
          if (state.w_lane0) begin
            next_state.irq_enable = state.w_byte;
          end
        end
        `IRQ_PRIORITY_OFFSET: begin
          if (state.w_lane0) begin
            next_state.priority_select_reg = state.w_byte[5:0];
          end
        end
        `IRQ_STATUS_OFFSET: begin
          // Status is read-only; the write is accepted and dropped.
          next_state.bresp = `AXI_RESP_OKAY;
        end
        default: begin
          next_state.bresp = `AXI_RESP_SLVERR;
        end
      endcase
    end
    next_state.awready = ~next_state.aw_full & ~next_state.bvalid;
    next_state.wready = ~next_state.w_full & ~next_state.bvalid;

    // Read channel: one read in flight, data one cycle after the address.
    if (state.rvalid && i_axil.rready) begin
      next_state.rvalid = 1'b0;
    end
    if (i_axil.arvalid && state.arready) begin
      next_state.rvalid = 1'b1;
      next_state.rresp = `AXI_RESP_OKAY;
      unique case ({i_axil.araddr[7:2], 2'b00})
        `IRQ_ENABLE_OFFSET: begin
          next_state.rdata = {24'h000000, state.irq_enable};
        end
        `IRQ_PRIORITY_OFFSET: begin
          next_state.rdata = {26'h0000000, state.priority_select_reg};
        end
        `IRQ_STATUS_OFFSET: begin
          next_state.rdata = status_word;
        end
        default: begin
          next_state.rdata = 32'h0000_0000;
          next_state.rresp = `AXI_RESP_SLVERR;
        end
      endcase
    end
    // Holding arready low while rvalid stands keeps a second read from overtaking the first.
    next_state.arready = ~next_state.rvalid;
  end

  // Reset is synchronous; nothing in the unit must act before the first clock edge.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state <= RESET_STATE;
    end else begin
      state <= next_state;
    end
  end

  // Outputs are plain views of registered state, so none has a combinational path.
  assign o_axil = '{
    awready: state.awready,
    wready: state.wready,
    bvalid: state.bvalid,
    bresp: state.bresp,
    arready: state.arready,
    rvalid: state.rvalid,
    rdata: state.rdata,
    rresp: state.rresp
  };

  assign o_vector = '{
    call_active: state.call_active,
    call_done: state.call_done,
    call_level: state.call_level,
    source: state.call_source,
    address: state.call_address
  };

  assign o_in_service = {state.in_svc_high, state.in_svc_low};

endmodule

// ---- test/irq_prio_chk.sv ----
// Port assertions for the priority unit.
// Assumes it is bound to irq_prio_unit and sees only its ports.
module irq_prio_chk (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire irq_prio_pkg::axil_req_type i_axil,
  input wire irq_prio_pkg::axil_resp_type o_axil,
  input wire irq_prio_pkg::pending_flags_type i_flags,
  input wire irq_prio_pkg::sequencer_event_type i_seq,
  input wire irq_prio_pkg::vector_call_type o_vector,
  input wire logic [1:0] o_in_service
);
  timeunit 1ns;
  timeprecision 1ns;
  import irq_prio_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_start;
    $rose(o_vector.call_active);
  endsequence
  property p_call_len;
    s_start |-> o_vector.call_active[*4] ##1 (o_vector.call_done && !o_vector.call_active);
  endproperty
  a_call_len: assert property (p_call_len) else $error("bad call length");
  property p_detect;
    s_start |-> $past(i_flags, 2) != '0;
  endproperty
  a_detect: assert property (p_detect) else $error("call without flag");
  property p_after_insn;
    s_start |-> $past(i_seq.insn_done && !i_seq.return_from_interrupt);
  endproperty
  a_after_insn: assert property (p_after_insn) else $error("call off boundary");
  property p_high_block;
    s_start |-> !$past(o_in_service[1]);
  endproperty
  a_high_block: assert property (p_high_block) else $error("high preempted");
  property p_preempt;
    s_start |-> !$past(o_in_service[0]) || o_vector.call_level;
  endproperty
  a_preempt: assert property (p_preempt) else $error("low preempted low");
  property p_ret;
    i_seq.return_from_interrupt && o_in_service == 2'h3 |=> o_in_service == 2'h1;
  endproperty
  a_ret: assert property (p_ret) else $error("bad level after return");
  property p_read;
    i_axil.arvalid && o_axil.arready |=> o_axil.rvalid;
  endproperty
  a_read: assert property (p_read) else $error("late read data");
  property p_write;
    i_axil.awvalid && o_axil.awready && i_axil.wvalid && o_axil.wready |-> ##2 o_axil.bvalid;
  endproperty
  a_write: assert property (p_write) else $error("late write reply");
endmodule

bind irq_prio_unit irq_prio_chk chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_axil(i_axil),
  .o_axil(o_axil), .i_flags(i_flags), .i_seq(i_seq), .o_vector(o_vector),
  .o_in_service(o_in_service));

// ---- test/cpu_seq_model.sv ----
// Core sequencer stand-in: instruction completions and returns.
// Assumes the bench pulses i_ret once per return.
module cpu_seq_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_hold,
  input wire logic i_slow,
  input wire logic i_ret,
  output irq_prio_pkg::sequencer_event_type o_seq
);
  timeunit 1ns;
  timeprecision 1ns;
  import irq_prio_pkg::*;
  logic [2:0] count;
  // Slow mode finishes one instruction in eight cycles, as a divide would.
  always @(posedge i_clk) begin
    count <= i_rst_n ? count + 3'h1 : 3'h0;
    o_seq.return_from_interrupt <= i_rst_n && i_ret;
    o_seq.insn_done <= i_rst_n && !i_hold && (!i_slow || count == 3'h7);
  end
endmodule

// ---- test/tb_top.sv ----
// Bench for the priority unit: registers over AXI4-Lite, then vector calls.
// Assumes the checker binds itself and the sequencer model drives i_seq.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import irq_prio_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hold = 1'b0;
  logic slow = 1'b0;
  logic ret = 1'b0;
  axil_req_type rq = '0;
  axil_resp_type rs;
  pending_flags_type flags = '0;
  sequencer_event_type seq;
  vector_call_type vec;
  logic [1:0] insv;
  int bad_count = 0;
  int check_count = 0;
  int calls = 0;
  int n;
  always #5 clk = ~clk;
  always @(negedge clk) if (vec.call_done === 1'b1) calls <= calls + 1;
  irq_prio_unit dut (.i_clk(clk), .i_rst_n(rst_n), .i_axil(rq), .o_axil(rs),
    .i_flags(flags), .i_seq(seq), .o_vector(vec), .o_in_service(insv));
  cpu_seq_model seq_model (.i_clk(clk), .i_rst_n(rst_n), .i_hold(hold), .i_slow(slow),
    .i_ret(ret), .o_seq(seq));
  task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e);
    logic aw_ok;
    logic w_ok;
    logic b_ok;
    logic [1:0] resp;
    @(posedge clk);
    rq.awvalid <= 1'b1;
    rq.awaddr <= a;
    rq.wvalid <= 1'b1;
    rq.wdata <= {24'h000000, d};
    rq.wstrb <= 4'hf;
    rq.bready <= 1'b1;
    n = 0;
    // Handshakes are judged on values settled before the edge, then acted on at it.
    do begin
      @(negedge clk);
      aw_ok = rq.awvalid & rs.awready;
      w_ok = rq.wvalid & rs.wready;
      b_ok = rs.bvalid;
      resp = rs.bresp;
      @(posedge clk);
      n++;
      if (aw_ok) rq.awvalid <= 1'b0;
      if (w_ok) rq.wvalid <= 1'b0;
    end while (b_ok !== 1'b1 && n < 50);
    rq.bready <= 1'b0;
    check("bresp", {b_ok, resp}, {1'b1, e});
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e);
    logic ar_ok;
    logic r_ok;
    logic [1:0] resp;
    logic [31:0] data;
    @(posedge clk);
    rq.arvalid <= 1'b1;
    rq.araddr <= a;
    rq.rready <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      ar_ok = rq.arvalid & rs.arready;
      r_ok = rs.rvalid;
      resp = rs.rresp;
      data = rs.rdata;
      @(posedge clk);
      n++;
      if (ar_ok) rq.arvalid <= 1'b0;
    end while (r_ok !== 1'b1 && n < 50);
    rq.rready <= 1'b0;
    check("read", {r_ok, resp, data}, {1'b1, e, 24'h000000, d});
  endtask
  task automatic set_flags(input logic [6:0] v);
    @(posedge clk);
    flags <= v;
  endtask
  task automatic wait_call(input logic [2:0] s, input logic l);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (vec.call_done !== 1'b1 && n < 60);
    check("call", {vec.call_done, vec.call_level, vec.source, vec.address},
      {1'b1, l, s, 16'h0003 + {10'h000, s, 3'h0}});
  endtask
  task automatic pulse_ret();
    @(posedge clk);
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
  endtask
  task automatic do_ret(input logic [1:0] e);
    pulse_ret();
    repeat (2) @(posedge clk);
    #1;
    check("in_service", insv, e);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(8'ha8, 8'h00, 2'b00);
    rdchk(8'hb8, 8'h00, 2'b00);
    rdchk(8'h10, 8'h00, 2'b10);
    rdchk(8'hc0, 8'h00, 2'b00);
    axw(8'h10, 8'h55, 2'b10);
    axw(8'ha8, 8'h7f, 2'b00);
    rdchk(8'ha8, 8'h7f, 2'b00);
    axw(8'hb8, 8'h3f, 2'b00);
    rdchk(8'hb8, 8'h3f, 2'b00);
    axw(8'hb8, 8'h00, 2'b00);
    $display("test registers done");
    set_flags(7'h7f);
    repeat (20) @(posedge clk);
    check("calls", calls, 0);
    axw(8'ha8, 8'h80, 2'b00);
    repeat (20) @(posedge clk);
    check("calls", calls, 0);
    set_flags(7'h00);
    axw(8'ha8, 8'h82, 2'b00);
    set_flags(7'h02);
    repeat (6) @(posedge clk);
    #1;
    check("fast", {vec.call_done, vec.address, insv}, {1'b1, 16'h000b, 2'b01});
    pulse_ret();
    wait_call(3'h1, 1'b0);
    set_flags(7'h00);
    do_ret(2'b00);
    $display("test latency done");
    axw(8'ha8, 8'hbf, 2'b00);
    axw(8'hb8, 8'h08, 2'b00);
    hold <= 1'b1;
    set_flags(7'h09);
    repeat (3) @(posedge clk);
    hold <= 1'b0;
    wait_call(3'h3, 1'b1);
    repeat (20) @(posedge clk);
    check("calls", calls, 3);
    set_flags(7'h01);
    pulse_ret();
    wait_call(3'h0, 1'b0);
    set_flags(7'h08);
    wait_call(3'h3, 1'b1);
    #1;
    check("nest", insv, 2'b11);
    set_flags(7'h00);
    do_ret(2'b01);
    do_ret(2'b00);
    $display("test levels done");
    axw(8'hb8, 8'h00, 2'b00);
    hold <= 1'b1;
    set_flags(7'h24);
    repeat (3) @(posedge clk);
    hold <= 1'b0;
    wait_call(3'h2, 1'b0);
    set_flags(7'h20);
    slow <= 1'b1;
    pulse_ret();
    wait_call(3'h4, 1'b0);
    set_flags(7'h00);
    do_ret(2'b00);
    $display("test ranking done");
    summarize();
  end
  // The whole run needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    $display("[FAIL] watchdog expected finish seen timeout");
    summarize();
  end
endmodule
